// *** inc/rpms_pkg.sv ***
// ****************************************************************
// shared constants and carrier types of the reset and port-mode block
// ****************************************************************
package rpms_pkg;

  // system clock rate of hclk
  localparam int unsigned CLK_HZ = 50_000_000;

  // ****************************************************************
  // register map, byte addresses on the ahb-lite slave
  // ****************************************************************
  localparam int ADDR_W = 8;                        // decoded address bits
  localparam logic [7:0] CTRL_OFF = 8'h00;          // control, read/write
  localparam logic [7:0] STATUS_OFF = 8'h04;        // live status, read only
  localparam logic [7:0] HOST_WORD_OFF = 8'h08;     // last host word, read only
  localparam logic [7:0] TX_WORD_OFF = 8'h0c;       // word shifted to the host

  // control field layout and reset value
  localparam int CTRL_LOCK_BIT = 0;                 // gate on the lock enable pin
  localparam logic CTRL_LOCK_RST = 1'b1;            // locking allowed by default

  // status field layout
  localparam int ST_TEST_BIT = 0;                   // port in test mode
  localparam int ST_RST_BIT = 1;                    // device held in reset
  localparam int ST_SWEN_BIT = 2;                   // synced lock enable pin
  localparam int ST_CS_BIT = 3;                     // synced chip select pin
  localparam int ST_TAP_LSB = 4;                    // test state, 4 bits
  localparam int ST_CNT_LSB = 8;                    // host bit count, 8 bits

  // host word width default and bit counter width
  localparam int HOST_WORD_W = 16;
  localparam int CNT_W = 8;

  // bus encodings
  localparam int HTRANS_ACT_BIT = 1;                // nonseq or seq
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;  // unmapped read value

  // test access sequence states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
    TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } rpms_tap_t;

  // shared serial port pins as they arrive
  typedef struct packed {
    logic sclk;    // serial bit clock / test clock
    logic sdin;    // serial data in / test data in
    logic cs_tms;  // chip select (active low) / test mode select
  } rpms_sport_t;

  // serial data out pin with its enable
  typedef struct packed {
    logic data;    // driven level
    logic oe;      // high while the pin is driven
  } rpms_sdout_t;

endpackage

// *** core/rpms_top.sv ***
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
// Summary of operation
// RULE1: host-mode reset: defaults, serial data out floated
// RULE2: reset released: normal operation resumes
// RULE3: test-mode reset: defaults and test sequence reset
// RULE4: test sequence advances only after reset release
// RULE5: select high routes serial port to test
// RULE6: select low: serial port is host interface
// RULE7: lock enable follows its control pin; here only while ctrl_lock is set and out of reset, low otherwise
// RULE8: host mode chip select is active low
// RULE9: all shifting follows the serial bit clock
// RULE10: reset asserts asynchronously, releases synchronised
module rpms_top #(
  parameter int HOST_W = rpms_pkg::HOST_WORD_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic reset_trst_n,
  input wire logic test_host_sel,
  input wire logic switch_line_lock_enable,
  input wire rpms_pkg::rpms_sport_t sport_i,
  output rpms_pkg::rpms_sdout_t sdout_o,
  output logic lock_enable,
  output logic func_rst_n,
  output logic port_test_mode
);

  // ****************************************************************
  // state of the block
  // ****************************************************************
  typedef struct packed {
    rpms_pkg::rpms_sport_t port_s1;   // first sync stage of port pins
    rpms_pkg::rpms_sport_t port_s2;   // second sync stage
    rpms_pkg::rpms_sport_t port_s3;   // history for edge finding
    logic sel_s1;                     // test/host select sync
    logic sel_s2;
    logic swen_s1;                    // lock enable pin sync
    logic swen_s2;
    logic ctrl_lock;                  // software gate on locking
    logic [HOST_W-1:0] tx_word;       // word offered to the host
    logic [HOST_W-1:0] host_word;     // last word the host wrote
    logic [HOST_W-1:0] rx_shift;      // incoming host bits
    logic [HOST_W-1:0] tx_shift;      // outgoing host bits
    logic [rpms_pkg::CNT_W-1:0] bit_cnt; // bits seen in this frame
    rpms_pkg::rpms_tap_t tap;         // test sequence state
    logic bypass;                     // one-bit data path in test
    logic [1:0] ir;                   // instruction shift path
    logic wr_pend;                    // write data phase pending
    logic [rpms_pkg::ADDR_W-1:0] wr_addr; // address of that write
    logic [31:0] hrdata;              // read data output
    logic hreadyout;                  // bus ready output
    rpms_pkg::rpms_sdout_t sdout;     // serial out pin
    logic lock_enable;                // lock enable output
    logic func_rst_n;                 // functional blocks out of reset
    logic test_mode;                  // port routed to test
  } rpms_state_t;

  rpms_state_t state_reg;
  rpms_state_t state_next;

  // ****************************************************************
  // reset synchroniser: async assert, sync release
  // ****************************************************************
  logic arst_n;        // either reset source low
  logic [1:0] rsync_reg;
  logic dev_rst_n;     // device reset, released on a clock edge

  assign arst_n = hresetn & reset_trst_n;

  // pin reset clears at once, leaves two edges after release
  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      rsync_reg <= 2'h0; // RULE10
    end else begin
      rsync_reg <= {rsync_reg[0], 1'b1}; // RULE10
    end
  end

  assign dev_rst_n = rsync_reg[1];

  // ****************************************************************
  // helpers
  // ****************************************************************
  // next test sequence state for a given mode select level
  function automatic rpms_pkg::rpms_tap_t tap_step(rpms_pkg::rpms_tap_t t, logic tms);
    rpms_pkg::rpms_tap_t n;
    n = t;
    case (t)
      rpms_pkg::TAP_RESET: n = tms ? rpms_pkg::TAP_RESET : rpms_pkg::TAP_IDLE;
      rpms_pkg::TAP_IDLE: n = tms ? rpms_pkg::TAP_SEL_DR : rpms_pkg::TAP_IDLE;
      rpms_pkg::TAP_SEL_DR: n = tms ? rpms_pkg::TAP_SEL_IR : rpms_pkg::TAP_CAP_DR;
      rpms_pkg::TAP_CAP_DR: n = tms ? rpms_pkg::TAP_EX1_DR : rpms_pkg::TAP_SH_DR;
      rpms_pkg::TAP_SH_DR: n = tms ? rpms_pkg::TAP_EX1_DR : rpms_pkg::TAP_SH_DR;
      rpms_pkg::TAP_EX1_DR: n = tms ? rpms_pkg::TAP_UPD_DR : rpms_pkg::TAP_PAU_DR;
      rpms_pkg::TAP_PAU_DR: n = tms ? rpms_pkg::TAP_EX2_DR : rpms_pkg::TAP_PAU_DR;
      rpms_pkg::TAP_EX2_DR: n = tms ? rpms_pkg::TAP_UPD_DR : rpms_pkg::TAP_SH_DR;
      rpms_pkg::TAP_UPD_DR: n = tms ? rpms_pkg::TAP_SEL_DR : rpms_pkg::TAP_IDLE;
      rpms_pkg::TAP_SEL_IR: n = tms ? rpms_pkg::TAP_RESET : rpms_pkg::TAP_CAP_IR;
      rpms_pkg::TAP_CAP_IR: n = tms ? rpms_pkg::TAP_EX1_IR : rpms_pkg::TAP_SH_IR;
      rpms_pkg::TAP_SH_IR: n = tms ? rpms_pkg::TAP_EX1_IR : rpms_pkg::TAP_SH_IR;
      rpms_pkg::TAP_EX1_IR: n = tms ? rpms_pkg::TAP_UPD_IR : rpms_pkg::TAP_PAU_IR;
      rpms_pkg::TAP_PAU_IR: n = tms ? rpms_pkg::TAP_EX2_IR : rpms_pkg::TAP_PAU_IR;
      rpms_pkg::TAP_EX2_IR: n = tms ? rpms_pkg::TAP_UPD_IR : rpms_pkg::TAP_SH_IR;
      rpms_pkg::TAP_UPD_IR: n = tms ? rpms_pkg::TAP_SEL_DR : rpms_pkg::TAP_IDLE;
      default: n = rpms_pkg::TAP_RESET;
    endcase
    return n;
  endfunction

  // read data for a decoded register address
  function automatic logic [31:0] rd_word(logic [rpms_pkg::ADDR_W-1:0] a, rpms_state_t s, logic rst_n);
    logic [31:0] w;
    w = rpms_pkg::RD_ZERO;
    if (a == rpms_pkg::CTRL_OFF) begin
      w[rpms_pkg::CTRL_LOCK_BIT] = s.ctrl_lock;
    end else if (a == rpms_pkg::STATUS_OFF) begin
      w[rpms_pkg::ST_TEST_BIT] = s.test_mode;
      w[rpms_pkg::ST_RST_BIT] = ~rst_n;
      w[rpms_pkg::ST_SWEN_BIT] = s.swen_s2;
      w[rpms_pkg::ST_CS_BIT] = s.port_s2.cs_tms;
      w[rpms_pkg::ST_TAP_LSB +: 4] = s.tap;
      w[rpms_pkg::ST_CNT_LSB +: rpms_pkg::CNT_W] = s.bit_cnt;
    end else if (a == rpms_pkg::HOST_WORD_OFF) begin
      w[HOST_W-1:0] = s.host_word;
    end else if (a == rpms_pkg::TX_WORD_OFF) begin
      w[HOST_W-1:0] = s.tx_word;
    end
    return w;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  logic sclk_rise;   // serial clock rising edge, synced
  logic sclk_fall;   // serial clock falling edge, synced
  logic cs_fall;     // host frame start
  logic cs_rise;     // host frame end
  logic host_on;     // host frame in progress
  logic test_on;     // port routed to test and out of reset
  logic addr_ok;     // valid address phase

  always_comb begin
    state_next = state_reg;
    // pin synchronisers, first stage read only by the second
    state_next.port_s1 = sport_i;
    state_next.port_s2 = state_reg.port_s1;
    state_next.port_s3 = state_reg.port_s2;
    state_next.sel_s1 = test_host_sel;
    state_next.sel_s2 = state_reg.sel_s1;
    state_next.swen_s1 = switch_line_lock_enable;
    state_next.swen_s2 = state_reg.swen_s1;
    sclk_rise = state_reg.port_s2.sclk & ~state_reg.port_s3.sclk; // RULE9
    sclk_fall = ~state_reg.port_s2.sclk & state_reg.port_s3.sclk; // RULE9
    cs_fall = ~state_reg.port_s2.cs_tms & state_reg.port_s3.cs_tms;
    cs_rise = state_reg.port_s2.cs_tms & ~state_reg.port_s3.cs_tms;
    state_next.test_mode = state_reg.sel_s2; // RULE5 RULE6
    test_on = state_reg.sel_s2 & dev_rst_n;
    host_on = ~state_reg.sel_s2 & dev_rst_n & ~state_reg.port_s2.cs_tms; // RULE8
    state_next.func_rst_n = dev_rst_n; // RULE2
    state_next.lock_enable = dev_rst_n & state_reg.swen_s2 & state_reg.ctrl_lock; // RULE7

    // ahb-lite: zero wait, registered read data, writes in data phase
    state_next.hreadyout = 1'b1;
    addr_ok = hsel & hready & htrans[rpms_pkg::HTRANS_ACT_BIT];
    state_next.wr_pend = addr_ok & hwrite;
    state_next.wr_addr = haddr[rpms_pkg::ADDR_W-1:0];
    if (addr_ok & ~hwrite) begin
      state_next.hrdata = rd_word(haddr[rpms_pkg::ADDR_W-1:0], state_reg, dev_rst_n);
    end
    if (state_reg.wr_pend) begin
      if (state_reg.wr_addr == rpms_pkg::CTRL_OFF) begin
        state_next.ctrl_lock = hwdata[rpms_pkg::CTRL_LOCK_BIT];
      end else if (state_reg.wr_addr == rpms_pkg::TX_WORD_OFF) begin
        state_next.tx_word = hwdata[HOST_W-1:0];
      end
    end

    // test path: advances on clock rises only when out of reset
    if (test_on) begin
      if (sclk_rise) begin
        state_next.tap = tap_step(state_reg.tap, state_reg.port_s2.cs_tms); // RULE4 RULE9
        if (state_reg.tap == rpms_pkg::TAP_SH_DR) begin
          state_next.bypass = state_reg.port_s2.sdin;
        end else if (state_reg.tap == rpms_pkg::TAP_SH_IR) begin
          state_next.ir = {state_reg.port_s2.sdin, state_reg.ir[1]};
        end
      end
      if (sclk_fall) begin
        // test data out changes on the falling edge while shifting
        state_next.sdout.oe = (state_reg.tap == rpms_pkg::TAP_SH_DR) |
                              (state_reg.tap == rpms_pkg::TAP_SH_IR); // RULE5
        state_next.sdout.data = (state_reg.tap == rpms_pkg::TAP_SH_DR) ? state_reg.bypass : state_reg.ir[0];
      end
    end else begin
      state_next.tap = rpms_pkg::TAP_RESET; // RULE3
    end

    // host path: frame opened by chip select low
    if (~state_reg.sel_s2 & dev_rst_n) begin
      if (cs_fall) begin
        state_next.tx_shift = state_reg.tx_word;
        state_next.bit_cnt = '0;
        state_next.sdout.data = state_reg.tx_word[HOST_W-1];
      end else if (host_on & sclk_rise) begin
        state_next.rx_shift = {state_reg.rx_shift[HOST_W-2:0], state_reg.port_s2.sdin}; // RULE9
        state_next.bit_cnt = state_reg.bit_cnt + 1'b1;
      end else if (host_on & sclk_fall) begin
        state_next.tx_shift = {state_reg.tx_shift[HOST_W-2:0], 1'b0}; // RULE9
        state_next.sdout.data = state_reg.tx_shift[HOST_W-2];
      end
      if (cs_rise) begin
        state_next.host_word = state_reg.rx_shift;
      end
      state_next.sdout.oe = host_on; // RULE6 RULE8
    end

    // device reset: control, host and test registers to defaults, pin floated
    if (!dev_rst_n) begin
      state_next.ctrl_lock = rpms_pkg::CTRL_LOCK_RST; // RULE1
      state_next.tx_word = '0; // RULE1
      state_next.host_word = '0;
      state_next.rx_shift = '0;
      state_next.tx_shift = '0;
      state_next.bit_cnt = '0;
      state_next.bypass = 1'b0;
      state_next.ir = 2'h0;
      state_next.tap = rpms_pkg::TAP_RESET; // RULE3
      state_next.sdout = '0; // RULE1
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
      state_reg.ctrl_lock <= rpms_pkg::CTRL_LOCK_RST;
      // chip select syncs start at the pin's idle high level, so no false frame edge follows reset
      state_reg.port_s1.cs_tms <= 1'b1;
      state_reg.port_s2.cs_tms <= 1'b1;
      state_reg.port_s3.cs_tms <= 1'b1;
      state_reg.tap <= rpms_pkg::TAP_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flops, hresp tied to okay
  assign hrdata = state_reg.hrdata;
  assign hreadyout = state_reg.hreadyout;
  assign hresp = rpms_pkg::HRESP_OKAY;
  assign sdout_o = state_reg.sdout;
  assign lock_enable = state_reg.lock_enable;
  assign func_rst_n = state_reg.func_rst_n;
  assign port_test_mode = state_reg.test_mode;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence reset_held_s;
    !dev_rst_n [*2];
  endsequence

  hiz_in_reset_a: assert property (!dev_rst_n |=> !sdout_o.oe) // RULE1
    else $error("serial out driven during reset");
  ctrl_default_a: assert property (!dev_rst_n |=> state_reg.ctrl_lock == rpms_pkg::CTRL_LOCK_RST) // RULE1
    else $error("control not at default in reset");
  func_release_a: assert property ($rose(dev_rst_n) |=> func_rst_n) // RULE2
    else $error("functional reset not released");
  tap_reset_a: assert property (reset_held_s |-> state_reg.tap == rpms_pkg::TAP_RESET) // RULE3
    else $error("test sequence not reset");
  tap_frozen_a: assert property ((!dev_rst_n || !state_reg.sel_s2) |=> state_reg.tap == rpms_pkg::TAP_RESET) // RULE4
    else $error("test sequence moved in reset");
  test_route_a: assert property (state_reg.sel_s2 |=> port_test_mode) // RULE5
    else $error("port not routed to test");
  host_route_a: assert property (!state_reg.sel_s2 && dev_rst_n && !state_reg.port_s2.cs_tms
      |=> sdout_o.oe) // RULE6
    else $error("host port not driving");
  lock_follow_a: assert property (dev_rst_n && state_reg.ctrl_lock
      |-> ##1 (lock_enable == $past(state_reg.swen_s2))) // RULE7
    else $error("lock enable not following pin");
  cs_deselect_a: assert property (!state_reg.sel_s2 && state_reg.port_s2.cs_tms |=> !sdout_o.oe) // RULE8
    else $error("driving with chip select high");
  bit_count_a: assert property (host_on && sclk_rise && !cs_fall
      |=> state_reg.bit_cnt == $past(state_reg.bit_cnt) + 8'h01) // RULE9
    else $error("host bit not counted on clock rise");
  rst_sync_a: assert property ($rose(dev_rst_n) |-> $past(arst_n, 1) && $past(arst_n, 2)) // RULE10
    else $error("reset released without synchronising");

endmodule

// *** sim/rpms_host_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// far side of the shared serial port: host controller or test controller
// ****************************************************************
module rpms_host_model (
  input wire logic hclk,
  output rpms_pkg::rpms_sport_t sport,
  input wire rpms_pkg::rpms_sdout_t sdout
);
  // link clock idles low, chip select idles high (deselected)
  initial begin
    sport = '{sclk: 1'b0, sdin: 1'b0, cs_tms: 1'b1};
  end

  // one host frame of 16 bits; cs_act high drives the select, low leaves it off
  task automatic frame(input logic cs_act, input logic [15:0] wd, output logic [15:0] rd, output int oe_n);
    oe_n = 0;
    @(posedge hclk);
    sport.cs_tms <= ~cs_act;
    repeat (4) @(posedge hclk);
    for (int i = 15; i >= 0; i--) begin
      sport.sdin <= wd[i];
      repeat (4) @(posedge hclk);
      sport.sclk <= 1'b1;
      repeat (2) @(posedge hclk);
      rd[i] = sdout.data;
      oe_n += int'(sdout.oe);
      repeat (2) @(posedge hclk);
      sport.sclk <= 1'b0;
    end
    repeat (4) @(posedge hclk);
    sport.cs_tms <= 1'b1;
    // released data line shows the inverse, never a stale level
    sport.sdin <= ~sport.sdin;
  endtask

  // one test clock period: mode select and data in, data out seen after the rise
  task automatic tap(input logic tms, input logic tdi, output logic tdo);
    sport.cs_tms <= tms;
    sport.sdin <= tdi;
    repeat (4) @(posedge hclk);
    sport.sclk <= 1'b1;
    repeat (2) @(posedge hclk);
    tdo = sdout.data;
    repeat (2) @(posedge hclk);
    sport.sclk <= 1'b0;
  endtask
endmodule

// *** sim/reset_and_port_mode_select_bench.sv ***
`timescale 1ns/1ps
`define RPMS_CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module reset_and_port_mode_select_bench;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, reset_trst_n, test_host_sel, switch_line_lock_enable;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, lock_enable, func_rst_n, port_test_mode;
  rpms_pkg::rpms_sport_t sport;
  rpms_pkg::rpms_sdout_t sdout;
  int seed, miscompares, total_checks, cyc, n;
  logic [31:0] exp_q[$];
  string nm_q[$];
  logic [31:0] res_val, e_w, rd, v, tx, wd;
  logic res_vld;
  string n_w;
  logic [15:0] rx;
  logic t, lo, hi;

  // 20 ns clock
  always #10 hclk = ~hclk;

  rpms_top #(.HOST_W(16)) rpms_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .reset_trst_n(reset_trst_n), .test_host_sel(test_host_sel),
    .switch_line_lock_enable(switch_line_lock_enable), .sport_i(sport), .sdout_o(sdout),
    .lock_enable(lock_enable), .func_rst_n(func_rst_n), .port_test_mode(port_test_mode)
  );
  rpms_host_model rpms_host_model_i (.hclk(hclk), .sport(sport), .sdout(sdout));

  // ****************************************************************
  // tasks
  // ****************************************************************
  // note the expectation, then present the result to the watcher
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    @(posedge hclk);
    nm_q.push_back(nm);
    exp_q.push_back(e);
    res_val <= g;
    res_vld <= 1'b1;
    @(posedge hclk);
    res_vld <= 1'b0;
    @(posedge hclk);
  endtask

  // single whole-word ahb-lite transfer, waits on hready in both phases
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  // counts, verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watcher: oldest note against each presented result
  always @(posedge hclk) begin
    if (res_vld) begin
      e_w = exp_q.pop_front();
      n_w = nm_q.pop_front();
      `RPMS_CHK(n_w, e_w, res_val)
    end
  end

  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed = 66346;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    reset_trst_n = 1'b1;
    test_host_sel = 1'b0;
    switch_line_lock_enable = 1'b0;
    res_vld = 1'b0;
    res_val = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    // defaults, unmapped and read-only places
    ahb(1'b0, rpms_pkg::CTRL_OFF, 32'h0, rd);
    chk("ctrl_default", 32'h1, rd);
    ahb(1'b1, rpms_pkg::STATUS_OFF, 32'hffff_ffff, rd);
    ahb(1'b0, 32'h0000_0010, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    chk("bus_okay", 32'h1, {30'h0, hresp, hreadyout});
    chk("host_mode", 32'h0, {31'h0, port_test_mode});
    // lock enable against its pin and the control gate
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      switch_line_lock_enable <= v[0];
      ahb(1'b1, rpms_pkg::CTRL_OFF, {31'h0, v[1]}, rd);
      repeat (6) @(posedge hclk);
      chk("lock_enable", {31'h0, v[0] & v[1]}, {31'h0, lock_enable});
    end
    // host frame: tx word out, random word in
    tx = {16'h0, 16'($random(seed))};
    wd = $random(seed);
    ahb(1'b1, rpms_pkg::TX_WORD_OFF, tx, rd);
    rpms_host_model_i.frame(1'b1, wd[15:0], rx, n);
    chk("sdout_word", tx, {16'h0, rx});
    chk("oe_in_frame", 32'h10, n);
    repeat (8) @(posedge hclk);
    chk("oe_after_frame", 32'h0, {31'h0, sdout.oe});
    ahb(1'b0, rpms_pkg::HOST_WORD_OFF, 32'h0, rd);
    chk("host_word", {16'h0, wd[15:0]}, rd);
    ahb(1'b0, rpms_pkg::STATUS_OFF, 32'h0, rd);
    chk("bit_count", 32'h10, {24'h0, rd[15:8]});
    // clocking with the select high must be ignored
    rpms_host_model_i.frame(1'b0, ~wd[15:0], rx, n);
    chk("oe_unselected", 32'h0, n);
    ahb(1'b0, rpms_pkg::HOST_WORD_OFF, 32'h0, rd);
    chk("host_word_kept", {16'h0, wd[15:0]}, rd);
    // device reset in host mode, then release timing
    switch_line_lock_enable <= 1'b1;
    ahb(1'b1, rpms_pkg::CTRL_OFF, 32'h0, rd);
    @(posedge hclk);
    reset_trst_n <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("func_rst_held", 32'h0, {31'h0, func_rst_n});
    chk("oe_in_reset", 32'h0, {31'h0, sdout.oe});
    ahb(1'b0, rpms_pkg::CTRL_OFF, 32'h0, rd);
    chk("ctrl_in_reset", 32'h1, rd);
    ahb(1'b0, rpms_pkg::STATUS_OFF, 32'h0, rd);
    chk("status_in_reset", 32'h1, {31'h0, rd[rpms_pkg::ST_RST_BIT]});
    @(posedge hclk);
    reset_trst_n <= 1'b1;
    repeat (3) @(posedge hclk);
    lo = func_rst_n;
    @(posedge hclk);
    hi = func_rst_n;
    chk("func_rst_edge3", 32'h0, {31'h0, lo});
    chk("func_rst_edge4", 32'h1, {31'h0, hi});
    chk("lock_after_reset", 32'h1, {31'h0, lock_enable});
    // test mode: bypass path through the shared port
    test_host_sel <= 1'b1;
    repeat (6) @(posedge hclk);
    chk("test_mode", 32'h1, {31'h0, port_test_mode});
    rpms_host_model_i.tap(1'b0, 1'b0, t);
    rpms_host_model_i.tap(1'b1, 1'b0, t);
    rpms_host_model_i.tap(1'b0, 1'b0, t);
    rpms_host_model_i.tap(1'b0, 1'b0, t);
    v = $random(seed);
    for (int i = 0; i < 9; i++) begin
      rpms_host_model_i.tap(1'b0, v[i], t);
      if (i > 0) begin
        chk("bypass_bit", {31'h0, v[i-1]}, {31'h0, t});
      end
    end
    ahb(1'b0, rpms_pkg::STATUS_OFF, 32'h0, rd);
    chk("state_shift", 32'h4, {28'h0, rd[7:4]});
    // walk over to the instruction path, then check its two-bit delay
    for (int i = 0; i < 6; i++) begin
      rpms_host_model_i.tap(i < 4, 1'b0, t);
    end
    for (int i = 0; i < 6; i++) begin
      rpms_host_model_i.tap(1'b0, v[i+9], t);
      if (i > 1) begin
        chk("ir_bit", {31'h0, v[i+7]}, {31'h0, t});
      end
    end
    // device reset in test mode holds the test sequence
    reset_trst_n <= 1'b0;
    rpms_host_model_i.tap(1'b0, 1'b0, t);
    rpms_host_model_i.tap(1'b0, 1'b0, t);
    ahb(1'b0, rpms_pkg::STATUS_OFF, 32'h0, rd);
    chk("state_reset", 32'h0, {28'h0, rd[7:4]});
    chk("func_rst_test", 32'h0, {31'h0, func_rst_n});
    reset_trst_n <= 1'b1;
    repeat (4) @(posedge hclk);
    rpms_host_model_i.tap(1'b0, 1'b0, t);
    ahb(1'b0, rpms_pkg::STATUS_OFF, 32'h0, rd);
    chk("state_resumed", 32'h1, {28'h0, rd[7:4]});
    repeat (4) @(posedge hclk);
    report_and_stop();
  end
endmodule
